// ==== exception_lowpower_pkg.sv ====
// Constants shared by the exception and low-power controller.
// Assumes a 32-bit APB bus; register byte address is four times the index.
package exception_lowpower_pkg;
  // Register indices (byte address = index * 4)
  localparam logic [15:0] IDX_BREAK_STATUS   = 16'hfe00;
  localparam logic [15:0] IDX_RESET_CAUSE    = 16'hfe01;
  localparam logic [15:0] IDX_BREAK_FLAG_CTL = 16'hfe03;
  localparam logic [15:0] IDX_IRQ_STATUS_ONE = 16'hfe04;
  localparam logic [15:0] IDX_IRQ_STATUS_TWO = 16'hfe05;
  localparam logic [15:0] IDX_IRQ_STATUS_THR = 16'hfe06;
  localparam logic [15:0] IDX_CONFIG_ONE     = 16'hfe07;
  // Field positions
  localparam int BIT_BREAK_LOWPWR   = 1;
  localparam int BIT_BREAK_CLR_EN   = 7;
  localparam int BIT_SHORT_RECOVERY = 0;
  localparam int BIT_WATCHDOG_DIS   = 1;
  localparam int BIT_PEND_KEYPAD    = 7;
  localparam int BIT_PEND_CONV      = 0;
  localparam int BIT_CAUSE_POWERUP  = 6;
  // Reset values
  localparam logic [7:0] RST_BREAK_FLAG_CTL = 8'h00;
  localparam logic [7:0] RST_CONFIG_ONE     = 8'h00;
  // Source order, highest priority first after the trap
  localparam int SRC_EXT = 0;
  localparam int SRC_CH0 = 1;
  localparam int SRC_CH1 = 2;
  localparam int SRC_OVF = 3;
  localparam int SRC_KBD = 4;
  localparam int SRC_ADC = 5;
  localparam int NUM_SRC = 6;
  // Vector addresses
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP  = 16'hfffc;
  localparam logic [15:0] VEC_EXT   = 16'hfffa;
  localparam logic [15:0] VEC_CH0   = 16'hfff6;
  localparam logic [15:0] VEC_CH1   = 16'hfff4;
  localparam logic [15:0] VEC_OVF   = 16'hfff2;
  localparam logic [15:0] VEC_KBD   = 16'hffe0;
  localparam logic [15:0] VEC_ADC   = 16'hffde;
  // Stop recovery in quad bus clock cycles
  localparam int LONG_RECOVERY_CYC  = 4096;
  localparam int SHORT_RECOVERY_CYC = 32;

  typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_STOP, PWR_RECOVER} pwr_state_t;
endpackage : exception_lowpower_pkg

// ==== exception_lowpower_ctrl.sv ====
// Exception arbitration, break handling and wait/stop sequencing.
// Assumes the core reports boundaries and acknowledges vector fetches; APB slave.
//
// Summary of operation
// R1: Latch arbitration winner; it keeps precedence until serviced or mask cleared. Here only vectorTaken releases it; clearing the mask does not.
// R2: Hardware requests are taken only at boundaries, unmasked and enabled.
// R3: Entry makes the core stack registers and set the global mask.
// R4: Entry never stacks the upper index byte.
// R5: Highest pending wins; pending at return is taken before next instruction.
// R6: Software trap is taken regardless of the global mask.
// R7: Trap stacks current PC; hardware interrupts stack PC minus one.
// R8: Fixed priority and vectors: reset, trap, pin, ch0, ch1, overflow, keypad, conversion.
// R9: Status one shows pin, ch0, ch1, overflow pending; bits 0,1,3,7 zero.
// R10: Status two bit 7 keypad; status three bit 0 conversion; other bits zero.
// R11: All resets share top priority and bypass arbitration.
// R12: Break output forces the core to the trap vector.
// R13: In break, peripheral flags clear only with break-clear enable set.
// R14: Two-step clears stay protected in break; second step after break clears.
// R15: Wait or stop clears the global mask and stops the core clock.
// R16: Wait stops core clock only; enabled interrupt or break wakes, stacking next cycle.
// R17: Break during wait or stop sets the low-power break status bit.
// R18: With watchdog disable clear, the watchdog runs, also during wait.
// R19: Stop gates oscillator clocks, holds counter reset, then times recovery.
// R20: Recovery lasts 4096 cycles, or 32 with short recovery selected.
// R21: Break status, reset cause and break flag control are memory mapped.
// R22: Reset cause holds seven origin flags, read clears, power-up clears others.
// R23: Cause flags in bits 7..1, bit 0 zero; break-clear enable bit 7, reset 0.
// R24: Core reports boundaries, accepts vectors and marks opcode fetches.
`timescale 1ns/1ps
module exception_lowpower_ctrl #(
  parameter int LONG_REC  = exception_lowpower_pkg::LONG_RECOVERY_CYC,
  parameter int SHORT_REC = exception_lowpower_pkg::SHORT_RECOVERY_CYC,
  parameter int ADDR_W    = 18
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Processor core
  input  wire logic                 instrDone,
  input  wire logic                 globalMask,
  input  wire logic                 trapExec,
  input  wire logic                 waitExec,
  input  wire logic                 stopExec,
  input  wire logic                 vectorTaken,
  output logic                      takeIrq,
  output logic [15:0]               vectorAddr,
  output logic                      stackPcMinusOne,
  output logic                      setGlobalMask,
  output logic                      clearGlobalMask,
  output logic                      coreClkEn,
  output logic                      periphClkEn,
  output logic                      oscEn,
  // Interrupt sources: flag and enable per source
  input  wire logic [5:0]           srcFlag,
  input  wire logic [5:0]           srcEnable,
  // Break module
  input  wire logic                 breakReq,
  output logic                      flagClearAllow,
  // Reset cause capture after release
  input  wire logic                 causeLoad,
  input  wire logic [6:0]           causeIn,
  // Watchdog
  output logic                      watchdogRun
);
  initial begin
    if (SHORT_REC < 1 || LONG_REC <= SHORT_REC || ADDR_W < 18) begin
      $error("exception_lowpower_ctrl: bad parameters");
    end
  end

  localparam int CNT_W = $clog2(LONG_REC + 1);

  // ==========================================================
  // Arbitration helpers
  function automatic logic [15:0] vecOf(input logic [5:0] pend);
    vecOf = exception_lowpower_pkg::VEC_ADC;
    if (pend[exception_lowpower_pkg::SRC_KBD]) vecOf = exception_lowpower_pkg::VEC_KBD;
    if (pend[exception_lowpower_pkg::SRC_OVF]) vecOf = exception_lowpower_pkg::VEC_OVF;
    if (pend[exception_lowpower_pkg::SRC_CH1]) vecOf = exception_lowpower_pkg::VEC_CH1;
    if (pend[exception_lowpower_pkg::SRC_CH0]) vecOf = exception_lowpower_pkg::VEC_CH0;
    if (pend[exception_lowpower_pkg::SRC_EXT]) vecOf = exception_lowpower_pkg::VEC_EXT;
  endfunction : vecOf

  function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    isReg = (a == ADDR_W'({idx, 2'b00}));
  endfunction : isReg

  logic [5:0] pending;
  assign pending = srcFlag & srcEnable; // R2

  // ==========================================================
  // Low-power sequencing
  exception_lowpower_pkg::pwr_state_t pwr_ff;
  exception_lowpower_pkg::pwr_state_t nxt_pwr;
  logic [CNT_W-1:0] recCnt_ff;
  logic             shortRec;
  logic             wake;
  logic [7:0]       configOne_ff;

  assign shortRec = configOne_ff[exception_lowpower_pkg::BIT_SHORT_RECOVERY];
  assign wake     = (|pending) | breakReq;

  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      exception_lowpower_pkg::PWR_RUN: begin
        if (stopExec) begin
          nxt_pwr = exception_lowpower_pkg::PWR_STOP;
        end else if (waitExec) begin
          nxt_pwr = exception_lowpower_pkg::PWR_WAIT;
        end
      end
      exception_lowpower_pkg::PWR_WAIT: begin
        if (wake) nxt_pwr = exception_lowpower_pkg::PWR_RUN; // R16
      end
      exception_lowpower_pkg::PWR_STOP: begin
        if (wake) nxt_pwr = exception_lowpower_pkg::PWR_RECOVER; // R19
      end
      exception_lowpower_pkg::PWR_RECOVER: begin
        if (recCnt_ff == CNT_W'(shortRec ? SHORT_REC - 1 : LONG_REC - 1)) begin
          nxt_pwr = exception_lowpower_pkg::PWR_RUN; // R20
        end
      end
      default: nxt_pwr = exception_lowpower_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= exception_lowpower_pkg::PWR_RUN;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // Counter held clear outside recovery, counts during it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recCnt_ff <= '0;
    end else if (pwr_ff == exception_lowpower_pkg::PWR_RECOVER) begin
      recCnt_ff <= recCnt_ff + CNT_W'(1); // R19
    end else begin
      recCnt_ff <= '0; // R19
    end
  end

  logic lowPower;
  assign lowPower        = (pwr_ff != exception_lowpower_pkg::PWR_RUN);
  assign coreClkEn       = !lowPower; // R15
  assign periphClkEn     = (pwr_ff != exception_lowpower_pkg::PWR_STOP); // R16
  assign oscEn           = (pwr_ff != exception_lowpower_pkg::PWR_STOP); // R19
  assign clearGlobalMask = (pwr_ff == exception_lowpower_pkg::PWR_RUN) && (waitExec || stopExec); // R15
  assign watchdogRun     = !configOne_ff[exception_lowpower_pkg::BIT_WATCHDOG_DIS]; // R18

  // ==========================================================
  // Latch and arbitrate
  logic        latched_ff;
  logic [15:0] vector_ff;
  logic        minusOne_ff;
  logic        take_ff;
  logic        boundary;
  logic        hwTake;
  logic        trapTake;
  logic        wokeNow;

  assign wokeNow  = lowPower && (nxt_pwr == exception_lowpower_pkg::PWR_RUN);
  assign boundary = (instrDone && !lowPower) || wokeNow; // R2 R16 R20
  assign trapTake = !latched_ff && (trapExec || (breakReq && !lowPower) || (wokeNow && breakReq)); // R6 R12
  assign hwTake   = !latched_ff && !trapTake && boundary && !globalMask && (|pending); // R1 R2

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_ff  <= 1'b0;
      vector_ff   <= exception_lowpower_pkg::VEC_RESET; // R11
      minusOne_ff <= 1'b0;
      take_ff     <= 1'b0;
    end else begin
      take_ff <= trapTake || hwTake; // R3
      if (trapTake) begin
        latched_ff  <= 1'b1;
        vector_ff   <= exception_lowpower_pkg::VEC_TRAP; // R8 R12
        minusOne_ff <= 1'b0; // R7
      end else if (hwTake) begin
        latched_ff  <= 1'b1; // R1
        vector_ff   <= vecOf(pending); // R5 R8
        minusOne_ff <= 1'b1; // R7
      end else if (latched_ff && vectorTaken) begin
        latched_ff <= 1'b0; // R1 R5
      end
    end
  end

  // Core stacks PC, A, X, CCR only; upper index byte is never pushed
  assign takeIrq         = take_ff; // R3 R4
  assign setGlobalMask   = take_ff; // R3
  assign vectorAddr      = vector_ff;
  assign stackPcMinusOne = minusOne_ff;

  // ==========================================================
  // Registers
  logic       rdStrobe;
  logic       wrStrobe;
  logic       mapped;
  logic [7:0] breakStatus_ff;
  logic [7:0] breakFlagCtl_ff;
  logic [7:0] resetCause_ff;
  logic [7:0] rdData;
  logic [31:0] prdata_ff;

  assign mapped = isReg(paddr, exception_lowpower_pkg::IDX_BREAK_STATUS) ||
                  isReg(paddr, exception_lowpower_pkg::IDX_RESET_CAUSE) ||
                  isReg(paddr, exception_lowpower_pkg::IDX_BREAK_FLAG_CTL) ||
                  isReg(paddr, exception_lowpower_pkg::IDX_IRQ_STATUS_ONE) ||
                  isReg(paddr, exception_lowpower_pkg::IDX_IRQ_STATUS_TWO) ||
                  isReg(paddr, exception_lowpower_pkg::IDX_IRQ_STATUS_THR) ||
                  isReg(paddr, exception_lowpower_pkg::IDX_CONFIG_ONE); // R21
  assign rdStrobe = psel && penable && !pwrite;
  assign wrStrobe = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  always_comb begin
    rdData = 8'h00;
    if (isReg(paddr, exception_lowpower_pkg::IDX_BREAK_STATUS)) rdData = breakStatus_ff;
    if (isReg(paddr, exception_lowpower_pkg::IDX_RESET_CAUSE)) rdData = resetCause_ff; // R22
    if (isReg(paddr, exception_lowpower_pkg::IDX_BREAK_FLAG_CTL)) rdData = breakFlagCtl_ff;
    if (isReg(paddr, exception_lowpower_pkg::IDX_IRQ_STATUS_ONE)) begin
      rdData = {1'b0, pending[exception_lowpower_pkg::SRC_OVF:exception_lowpower_pkg::SRC_CH0],
                1'b0, pending[exception_lowpower_pkg::SRC_EXT], 2'b00}; // R9
    end
    if (isReg(paddr, exception_lowpower_pkg::IDX_IRQ_STATUS_TWO)) begin
      rdData[exception_lowpower_pkg::BIT_PEND_KEYPAD] = pending[exception_lowpower_pkg::SRC_KBD]; // R10
    end
    if (isReg(paddr, exception_lowpower_pkg::IDX_IRQ_STATUS_THR)) begin
      rdData[exception_lowpower_pkg::BIT_PEND_CONV] = pending[exception_lowpower_pkg::SRC_ADC]; // R10
    end
    if (isReg(paddr, exception_lowpower_pkg::IDX_CONFIG_ONE)) rdData = configOne_ff;
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_ff <= {24'h00_0000, rdData};
    end
  end
  assign prdata = prdata_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      breakFlagCtl_ff <= exception_lowpower_pkg::RST_BREAK_FLAG_CTL; // R23
      configOne_ff    <= exception_lowpower_pkg::RST_CONFIG_ONE;
    end else if (wrStrobe) begin
      if (isReg(paddr, exception_lowpower_pkg::IDX_BREAK_FLAG_CTL)) begin
        breakFlagCtl_ff <= {pwdata[exception_lowpower_pkg::BIT_BREAK_CLR_EN], 7'h00}; // R23
      end
      if (isReg(paddr, exception_lowpower_pkg::IDX_CONFIG_ONE)) begin
        configOne_ff <= {6'h00, pwdata[1:0]};
      end
    end
  end

  // Low-power break bit: writing 0 clears, a new break wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      breakStatus_ff <= 8'h00;
    end else if (breakReq && lowPower) begin
      breakStatus_ff[exception_lowpower_pkg::BIT_BREAK_LOWPWR] <= 1'b1; // R17
    end else if (wrStrobe && isReg(paddr, exception_lowpower_pkg::IDX_BREAK_STATUS) &&
                 !pwdata[exception_lowpower_pkg::BIT_BREAK_LOWPWR]) begin
      breakStatus_ff[exception_lowpower_pkg::BIT_BREAK_LOWPWR] <= 1'b0;
    end
  end

  // Cause load wins over a read clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetCause_ff <= 8'h00;
    end else if (causeLoad) begin
      if (causeIn[exception_lowpower_pkg::BIT_CAUSE_POWERUP]) begin
        resetCause_ff <= 8'h80; // R22 R23
      end else begin
        resetCause_ff <= {causeIn, 1'b0}; // R23
      end
    end else if (rdStrobe && isReg(paddr, exception_lowpower_pkg::IDX_RESET_CAUSE)) begin
      resetCause_ff <= 8'h00; // R22
    end
  end

  // Break state follows the break output; peripherals gate their clears on this
  assign flagClearAllow = !breakReq || breakFlagCtl_ff[exception_lowpower_pkg::BIT_BREAK_CLR_EN]; // R13 R14

  // ==========================================================
  // Assertions
  sequence s_stopEnter;
    (pwr_ff == exception_lowpower_pkg::PWR_RUN) && stopExec;
  endsequence
  sequence s_recoverStart;
    (pwr_ff == exception_lowpower_pkg::PWR_STOP) && wake && shortRec;
  endsequence

  property p_hwAtBoundary;
    @(posedge clk) disable iff (!rst_n) hwTake |-> boundary && !globalMask;
  endproperty
  a_hwAtBoundary: assert property (p_hwAtBoundary) else $error("hw interrupt off boundary"); // R2

  property p_latchHolds;
    @(posedge clk) disable iff (!rst_n) latched_ff && !vectorTaken |=> $stable(vector_ff);
  endproperty
  a_latchHolds: assert property (p_latchHolds) else $error("latched vector changed"); // R1

  property p_trapVector;
    @(posedge clk) disable iff (!rst_n)
      trapTake |=> vectorAddr == exception_lowpower_pkg::VEC_TRAP && !stackPcMinusOne && takeIrq;
  endproperty
  a_trapVector: assert property (p_trapVector) else $error("trap vector wrong"); // R6

  property p_hwMinusOne;
    @(posedge clk) disable iff (!rst_n) hwTake |=> stackPcMinusOne && setGlobalMask;
  endproperty
  a_hwMinusOne: assert property (p_hwMinusOne) else $error("hw entry stack flag wrong"); // R7

  property p_priority;
    @(posedge clk) disable iff (!rst_n)
      hwTake && pending[exception_lowpower_pkg::SRC_EXT] |=> vectorAddr == exception_lowpower_pkg::VEC_EXT;
  endproperty
  a_priority: assert property (p_priority) else $error("pin request not first"); // R8

  property p_stopClocks;
    @(posedge clk) disable iff (!rst_n) s_stopEnter |=> !oscEn && !coreClkEn && recCnt_ff == '0;
  endproperty
  a_stopClocks: assert property (p_stopClocks) else $error("stop did not gate clocks"); // R19

  property p_shortRecovery;
    @(posedge clk) disable iff (!rst_n)
      s_recoverStart |-> ##SHORT_REC (pwr_ff == exception_lowpower_pkg::PWR_RECOVER)
        ##1 (pwr_ff == exception_lowpower_pkg::PWR_RUN);
  endproperty
  a_shortRecovery: assert property (p_shortRecovery) else $error("short recovery length wrong"); // R20

  property p_causeClear;
    @(posedge clk) disable iff (!rst_n)
      rdStrobe && !causeLoad && isReg(paddr, exception_lowpower_pkg::IDX_RESET_CAUSE) |=> resetCause_ff == 8'h00;
  endproperty
  a_causeClear: assert property (p_causeClear) else $error("reset cause not cleared"); // R22

  property p_breakLowPower;
    @(posedge clk) disable iff (!rst_n)
      breakReq && lowPower |=> breakStatus_ff[exception_lowpower_pkg::BIT_BREAK_LOWPWR];
  endproperty
  a_breakLowPower: assert property (p_breakLowPower) else $error("break in low power not flagged"); // R17

  property p_waitWake;
    @(posedge clk) disable iff (!rst_n)
      pwr_ff == exception_lowpower_pkg::PWR_WAIT && (|pending) && !globalMask && !latched_ff |=> takeIrq;
  endproperty
  a_waitWake: assert property (p_waitWake) else $error("wait wake did not stack"); // R16
endmodule : exception_lowpower_ctrl

// ==== core_model.sv ====
// Behavioural processor core on the far side of the exception controller.
// Assumes bench pulses step, sei and cli, and that lag is never 0.
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bench controls
  input  wire logic       step,
  input  wire logic       sei,
  input  wire logic       cli,
  input  wire logic [3:0] lag,
  // Controller side
  input  wire logic       takeIrq,
  input  wire logic       setGlobalMask,
  input  wire logic       clearGlobalMask,
  input  wire logic       coreClkEn,
  output logic            instrDone,
  output logic            globalMask,
  output logic            vectorTaken
);
  logic [3:0] lagCnt_ff;

  // ==========================================
  // Boundaries only while the core is clocked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) instrDone <= 1'b0;
    else instrDone <= step & coreClkEn;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) globalMask <= 1'b1;
    else if (setGlobalMask | sei) globalMask <= 1'b1;
    else if (clearGlobalMask | cli) globalMask <= 1'b0;
  end

  // Vector fetch comes lag + 1 cycles after entry starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lagCnt_ff   <= 4'h0;
      vectorTaken <= 1'b0;
    end else begin
      vectorTaken <= (lagCnt_ff == 4'h1);
      if (takeIrq) lagCnt_ff <= lag;
      else if (lagCnt_ff != 4'h0) lagCnt_ff <= lagCnt_ff - 4'h1;
    end
  end
endmodule : core_model

// ==== tb_top.sv ====
// Self-checking bench for the exception and low-power controller.
// Assumes the controller package and the core_model partner are compiled first.
`timescale 1ns/1ps
module tb_top;
  localparam int LREC = 64;
  localparam int SREC = exception_lowpower_pkg::SHORT_RECOVERY_CYC;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic        instrDone, globalMask, trapExec, waitExec, stopExec, vectorTaken;
  logic        takeIrq, stackPcMinusOne, setGlobalMask, clearGlobalMask;
  logic        coreClkEn, periphClkEn, oscEn, breakReq, flagClearAllow;
  logic        causeLoad, watchdogRun, step, sei, cli;
  logic [15:0] vectorAddr;
  logic [5:0]  srcFlag, srcEnable, pend;
  logic [6:0]  causeIn;
  logic [4:0]  cmd;
  logic [3:0]  lag;
  int          mismatches, check_count, n;

  assign {causeLoad, stopExec, waitExec, trapExec, step} = cmd;

  exception_lowpower_ctrl #(.LONG_REC(LREC)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instrDone(instrDone), .globalMask(globalMask), .trapExec(trapExec),
    .waitExec(waitExec), .stopExec(stopExec), .vectorTaken(vectorTaken),
    .takeIrq(takeIrq), .vectorAddr(vectorAddr), .stackPcMinusOne(stackPcMinusOne),
    .setGlobalMask(setGlobalMask), .clearGlobalMask(clearGlobalMask),
    .coreClkEn(coreClkEn), .periphClkEn(periphClkEn), .oscEn(oscEn),
    .srcFlag(srcFlag), .srcEnable(srcEnable), .breakReq(breakReq),
    .flagClearAllow(flagClearAllow), .causeLoad(causeLoad), .causeIn(causeIn),
    .watchdogRun(watchdogRun));

  core_model core_u (
    .clk(clk), .rst_n(rst_n), .step(step), .sei(sei), .cli(cli), .lag(lag),
    .takeIrq(takeIrq), .setGlobalMask(setGlobalMask), .clearGlobalMask(clearGlobalMask),
    .coreClkEn(coreClkEn), .instrDone(instrDone), .globalMask(globalMask),
    .vectorTaken(vectorTaken));

  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [15:0] vecOf(input logic [5:0] p);
    if (p[0]) return exception_lowpower_pkg::VEC_EXT;
    if (p[1]) return exception_lowpower_pkg::VEC_CH0;
    if (p[2]) return exception_lowpower_pkg::VEC_CH1;
    if (p[3]) return exception_lowpower_pkg::VEC_OVF;
    if (p[4]) return exception_lowpower_pkg::VEC_KBD;
    return exception_lowpower_pkg::VEC_ADC;
  endfunction : vecOf

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic fire(input logic [4:0] m);
    @(posedge clk);
    cmd <= m;
    @(posedge clk);
    cmd <= 5'h0;
  endtask : fire

  task automatic waitTake(input int lim, output int cyc);
    cyc = -1;
    for (int i = 1; i <= lim; i++) begin
      @(negedge clk);
      if (takeIrq === 1'b1) begin
        cyc = i;
        break;
      end
    end
  endtask : waitTake

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, breakReq, sei, cli} = '0;
    {srcFlag, srcEnable, causeIn, cmd} = '0;
    lag = 4'h2;
    rnd = 32'd87930;
    mismatches = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, exception_lowpower_pkg::IDX_BREAK_FLAG_CTL, 8'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'hfe02, 8'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    chk(watchdogRun, 1'b1);
    causeIn <= 7'h40;
    fire(5'h10);
    apb(1'b0, exception_lowpower_pkg::IDX_RESET_CAUSE, 8'h0);
    chk(rd, 32'h80);
    apb(1'b0, exception_lowpower_pkg::IDX_RESET_CAUSE, 8'h0);
    chk(rd, 32'h0);
    rnd = lfsr(rnd);
    causeIn <= {1'b0, rnd[5:0]};
    fire(5'h10);
    apb(1'b0, exception_lowpower_pkg::IDX_RESET_CAUSE, 8'h0);
    chk(rd, {rnd[5:0], 1'b0});
    $display("test registers done");
    for (int k = 0; k < 16; k++) begin
      rnd = lfsr(rnd);
      pend = rnd[5:0] & rnd[11:6];
      @(posedge clk);
      {srcFlag, srcEnable} <= rnd[11:0];
      cli <= 1'b1;
      @(posedge clk);
      cli <= 1'b0;
      apb(1'b0, exception_lowpower_pkg::IDX_IRQ_STATUS_ONE, 8'h0);
      chk(rd, {pend[3:1], 1'b0, pend[0], 2'b00});
      apb(1'b0, exception_lowpower_pkg::IDX_IRQ_STATUS_TWO, 8'h0);
      chk(rd, {pend[4], 7'h0});
      apb(1'b0, exception_lowpower_pkg::IDX_IRQ_STATUS_THR, 8'h0);
      chk(rd, pend[5]);
      fire(5'h01);
      waitTake(6, n);
      chk(n > 0, pend != 6'h0);
      if (n > 0) chk({vectorAddr, stackPcMinusOne, setGlobalMask}, {vecOf(pend), 2'b11});
      repeat (4) @(posedge clk);
    end
    $display("test priority done");
    lag <= 4'hf;
    srcFlag <= 6'h20;
    srcEnable <= 6'h3f;
    cli <= 1'b1;
    @(posedge clk);
    cli <= 1'b0;
    fire(5'h01);
    waitTake(6, n);
    chk(vectorAddr, exception_lowpower_pkg::VEC_ADC);
    @(posedge clk);
    srcFlag <= 6'h21;
    cli <= 1'b1;
    @(posedge clk);
    cli <= 1'b0;
    fire(5'h01);
    waitTake(4, n);
    chk(n, -1);
    repeat (10) @(posedge clk);
    lag <= 4'h2;
    cli <= 1'b1;
    @(posedge clk);
    cli <= 1'b0;
    fire(5'h01);
    waitTake(6, n);
    chk(vectorAddr, exception_lowpower_pkg::VEC_EXT);
    repeat (4) @(posedge clk);
    sei <= 1'b1;
    @(posedge clk);
    sei <= 1'b0;
    fire(5'h01);
    waitTake(6, n);
    chk(n, -1);
    fire(5'h02);
    waitTake(6, n);
    chk({vectorAddr, stackPcMinusOne}, {exception_lowpower_pkg::VEC_TRAP, 1'b0});
    $display("test latch and trap done");
    @(posedge clk);
    srcFlag <= 6'h0;
    breakReq <= 1'b1;
    waitTake(6, n);
    chk(vectorAddr, exception_lowpower_pkg::VEC_TRAP);
    chk(flagClearAllow, 1'b0);
    apb(1'b1, exception_lowpower_pkg::IDX_BREAK_FLAG_CTL, 8'h80);
    @(negedge clk);
    chk(flagClearAllow, 1'b1);
    apb(1'b0, exception_lowpower_pkg::IDX_BREAK_FLAG_CTL, 8'h0);
    chk(rd, 32'h80);
    breakReq <= 1'b0;
    apb(1'b1, exception_lowpower_pkg::IDX_BREAK_FLAG_CTL, 8'h0);
    @(negedge clk);
    chk(flagClearAllow, 1'b1);
    apb(1'b1, exception_lowpower_pkg::IDX_CONFIG_ONE, 8'h02);
    @(negedge clk);
    chk(watchdogRun, 1'b0);
    apb(1'b1, exception_lowpower_pkg::IDX_CONFIG_ONE, 8'h00);
    @(negedge clk);
    chk(watchdogRun, 1'b1);
    $display("test break done");
    repeat (8) @(posedge clk);
    cmd <= 5'h04;
    @(negedge clk);
    chk(clearGlobalMask, 1'b1);
    @(posedge clk);
    cmd <= 5'h0;
    @(negedge clk);
    chk({coreClkEn, periphClkEn, watchdogRun}, 3'b011);
    @(posedge clk);
    breakReq <= 1'b1;
    waitTake(6, n);
    chk(vectorAddr, exception_lowpower_pkg::VEC_TRAP);
    @(posedge clk);
    breakReq <= 1'b0;
    apb(1'b0, exception_lowpower_pkg::IDX_BREAK_STATUS, 8'h0);
    chk(rd[1], 1'b1);
    apb(1'b1, exception_lowpower_pkg::IDX_BREAK_STATUS, 8'h0);
    apb(1'b0, exception_lowpower_pkg::IDX_BREAK_STATUS, 8'h0);
    chk(rd[1], 1'b0);
    fire(5'h04);
    @(posedge clk);
    srcFlag <= 6'h01;
    waitTake(4, n);
    chk(n inside {[1:3]}, 1'b1);
    $display("test wait done");
    for (int sh = 0; sh < 2; sh++) begin
      apb(1'b1, exception_lowpower_pkg::IDX_CONFIG_ONE, 8'(sh));
      srcFlag <= 6'h0;
      repeat (6) @(posedge clk);
      fire(5'h08);
      @(negedge clk);
      chk({oscEn, periphClkEn, coreClkEn}, 3'b000);
      @(posedge clk);
      srcFlag <= 6'h01;
      waitTake(200, n);
      chk(n inside {[(sh ? SREC : LREC):(sh ? SREC : LREC) + 3]}, 1'b1);
      chk(vectorAddr, exception_lowpower_pkg::VEC_EXT);
    end
    $display("test stop done");
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk({takeIrq, vectorAddr}, {1'b0, exception_lowpower_pkg::VEC_RESET});
    end_of_test();
  end
endmodule : tb_top
